// >>> core/mcd_field_decoder.sv
`timescale 1ns/10ps
// Summary of operation
// - fixed codes force greater or less condition
// - zero test sets equal else greater
// - clear-op clears pending bits per u-bus
// - u-bus bit 10 disables interrupts until reset or power fail
// - clear-op copies instruction, flags, lamp, freeze
// - carry reset and set codes
// - flag one and two set/reset codes, flag three reset code
// - indirect bit cleared until fetch or instruction copy rearms
// - overflow reset and set codes
// - carry, u-bus bit moves to flags
// - depth counter increment and decrement
// - name and general counter increment
// - halt clears run bit of status two
// - pop: depth down, name up
// - pop with sign condition code
// - set interrupt stack and dispatcher flags
// - depth zero; no other depth use
// - drive or load target and op codes
// - clear-write request marks address word
// - read without restore into operand
// - read-restore destinations and direct load
// - r-bus zero load and stack fetch
// - equal code and idle code
module mcd_field_decoder import mcd_pkg::*; #(
  parameter int CNT_W = 16
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_exec,
  input  wire logic [4:0]        i_special,
  input  wire logic [4:0]        i_mcu_opt,
  input  wire logic [3:0]        i_rbus_code,
  input  wire logic [15:0]       i_tbus,
  input  wire logic [15:0]       i_ubus,
  input  wire logic [15:0]       i_cor,
  input  wire logic [15:0]       i_scratch_pad_one,
  input  wire logic [15:0]       i_cdb,
  input  wire logic [15:0]       i_tos_0,
  input  wire logic [15:0]       i_tos_1,
  input  wire logic [15:0]       i_tos_2,
  input  wire logic [15:0]       i_tos_3,
  input  wire logic              i_fetch_rearm,
  input  wire logic              i_reset_switch,
  input  wire logic              i_power_fail,
  output logic      [1:0]        o_cond_code,
  output logic                   o_carry,
  output logic                   o_flag1,
  output logic                   o_flag2,
  output logic                   o_flag3,
  output logic                   o_overflow,
  output logic                   o_indirect,
  output logic      [2:0]        o_depth,
  output logic      [1:0]        o_name,
  output logic      [CNT_W-1:0]  o_counter,
  output logic      [15:0]       o_int_pending,
  output logic      [15:0]       o_int_status2,
  output logic                   o_int_enable,
  output logic                   o_panel_lamp,
  output logic                   o_freeze,
  output logic      [15:0]       o_current_instr,
  output logic      [15:0]       o_next_instr,
  output logic                   o_ubus0,
  output logic                   o_ubus0_oe,
  output logic      [15:0]       o_cdb_data,
  output logic                   o_cdb_oe,
  output logic                   o_mem_req,
  output mcd_mem_op_t            o_mem_op,
  output logic      [15:0]       o_rbus
);

  // word bits are numbered from the msb, as the microcode sees them
  function automatic logic wbit(input logic [15:0] w, input int n);
    wbit = w[15-n];
  endfunction : wbit

  function automatic logic [1:0] sign_cond(input logic [15:0] w);
    if (wbit(w, 0)) sign_cond = CC_LESS;
    else if (w == 16'h0000) sign_cond = CC_EQUAL;
    else sign_cond = CC_GREATER;
  endfunction : sign_cond

  logic [1:0]  sync1_q, sync2_q;
  logic        sp, clr_op, wr_acc, pop;
  logic [15:0] pend_clr, pend_set, st2_set;
  logic        int_rearm;
  logic [1:0]  target_code_reg_q;
  logic [2:0]  memory_op_code_reg_q;
  logic [1:0]  tos_sel;

  assign sp       = i_exec;
  assign clr_op   = sp && (i_special == SP_INT_CLEAR);
  assign pop      = sp && (i_special == SP_POP
                        || i_special == SP_POP_COND);
  assign wr_acc   = i_psel && i_penable && i_pwrite;
  assign int_rearm = sync2_q[0] | sync2_q[1];

  // panel switch and power fail arrive asynchronously
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {i_power_fail, i_reset_switch};
      sync2_q <= sync1_q;
    end
  end

  // condition code
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cond_code <= CC_GREATER;
    end else if (sp) begin
      unique case (i_special)
        SP_COND_GREATER: o_cond_code <= CC_GREATER;
        SP_COND_LESS:    o_cond_code <= CC_LESS;
        SP_COND_EQUAL:   o_cond_code <= CC_EQUAL;
        SP_COND_ZERO:    o_cond_code <= (i_tbus == 16'h0000) ?
                                        CC_EQUAL : CC_GREATER;
        SP_COND_SIGN,
        SP_POP_COND:     o_cond_code <= sign_cond(i_tbus);
        default:         o_cond_code <= o_cond_code;
      endcase
    end
  end

  // carry, overflow and cpu flags
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_carry    <= 1'b0;
      o_overflow <= 1'b0;
      o_flag1    <= 1'b0;
      o_flag2    <= 1'b0;
      o_flag3    <= 1'b0;
    end else if (sp) begin
      unique case (i_special)
        SP_CARRY_RESET:   o_carry    <= 1'b0;
        SP_CARRY_SET:     o_carry    <= 1'b1;
        SP_OVF_RESET:     o_overflow <= 1'b0;
        SP_OVF_SET:       o_overflow <= 1'b1;
        SP_FLAG1_RESET:   o_flag1    <= 1'b0;
        SP_FLAG1_SET:     o_flag1    <= 1'b1;
        SP_FLAG2_RESET:   o_flag2    <= 1'b0;
        SP_FLAG2_SET:     o_flag2    <= 1'b1;
        SP_FLAG3_RESET:   o_flag3    <= 1'b0;
        SP_CARRY_TO_FLAG: o_flag1    <= o_carry;
        SP_TOP_TO_FLAG:   o_flag1    <= wbit(i_ubus, 0);
        SP_LOW_TO_FLAG:   o_flag2    <= wbit(i_ubus, 15);
        default:          o_flag3    <= o_flag3;
      endcase
    end
  end

  // flag one onto u-bus bit 0 for the whole microcycle
  assign o_ubus0_oe = sp && (i_special == SP_FLAG_TO_TOP);
  assign o_ubus0    = o_flag1;

  // indirect bit: stays clear until a fetch or instruction copy
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_indirect <= IND_RST;
    end else if (i_fetch_rearm
                 || (clr_op && wbit(i_ubus, UB_COPY_INSTR))) begin
      o_indirect <= 1'b1;
    end else if (sp && i_special == SP_IND_RESET) begin
      o_indirect <= 1'b0;
    end
  end

  // stack depth, name and general counter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_depth   <= 3'h0;
      o_name    <= 2'h0;
      o_counter <= '0;
    end else if (sp) begin
      unique case (i_special)
        SP_DEPTH_ZERO: o_depth <= 3'h0;
        SP_DEPTH_INC:  o_depth <= o_depth + 3'h1;
        SP_DEPTH_DEC:  o_depth <= o_depth - 3'h1;
        SP_NAME_INC:   o_name  <= o_name + 2'h1;
        SP_COUNT_INC:  o_counter <= o_counter + CNT_W'(1);
        SP_POP,
        SP_POP_COND: begin
          o_depth <= o_depth - 3'h1;
          o_name  <= o_name + 2'h1;
        end
        default:       o_name <= o_name;
      endcase
    end
  end

  // pending interrupt clears; a software set in the same cycle wins
  always_comb begin
    pend_clr = 16'h0000;
    if (clr_op) begin
      for (int i = PEND_FIRST; i <= PEND_PANEL; i++) begin
        pend_clr[i] = wbit(i_ubus, i);
      end
      pend_clr[PEND_PANEL] = wbit(i_ubus, PEND_PANEL)
                           | wbit(i_ubus, UB_PANEL_ALT);
    end
    pend_set = (wr_acc && i_paddr == A_PEND) ? i_pwdata[15:0] : 16'h0000;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_pending <= 16'h0000;
    end else begin
      o_int_pending <= (o_int_pending & ~pend_clr) | pend_set;
    end
  end

  // interrupt status two: run, interrupt stack and dispatcher bits
  always_comb begin
    st2_set = 16'h0000;
    if (wr_acc && i_paddr == A_STAT2) begin
      st2_set[X2_RUN] = i_pwdata[X2_RUN];
    end
    if (sp && i_special == SP_ISTK_SET) st2_set[X2_ISTK] = 1'b1;
    if (sp && i_special == SP_DISP_SET) st2_set[X2_DISP] = 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_status2 <= STAT2_RST;
    end else begin
      if (sp && i_special == SP_HALT) begin
        o_int_status2[X2_RUN] <= st2_set[X2_RUN];
      end else begin
        o_int_status2[X2_RUN] <= o_int_status2[X2_RUN] | st2_set[X2_RUN];
      end
      o_int_status2[X2_ISTK] <= st2_set[X2_ISTK] | (o_int_status2[X2_ISTK]
        & ~(clr_op && wbit(i_ubus, UB_ISTK_CLR)));
      o_int_status2[X2_DISP] <= st2_set[X2_DISP] | (o_int_status2[X2_DISP]
        & ~(clr_op && wbit(i_ubus, UB_DISP_CLR)));
    end
  end

  // master interrupt enable, lamp, freeze
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_enable <= INT_EN_RST;
      o_panel_lamp <= 1'b0;
      o_freeze     <= 1'b0;
    end else begin
      if (int_rearm) o_int_enable <= 1'b1;
      else if (clr_op && wbit(i_ubus, UB_INT_OFF))
        o_int_enable <= 1'b0;
      if (clr_op && wbit(i_ubus, UB_LAMP)) o_panel_lamp <= 1'b1;
      // only the cpu reset switch releases a frozen processor
      if (sync2_q[0]) o_freeze <= 1'b0;
      else if (clr_op && wbit(i_ubus, UB_FREEZE)) o_freeze <= 1'b1;
    end
  end

  // instruction registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_next_instr    <= 16'h0000;
      o_current_instr <= 16'h0000;
    end else begin
      if (sp && i_mcu_opt == MO_NEXT_LOAD) o_next_instr <= i_cdb;
      if (clr_op && wbit(i_ubus, UB_COPY_INSTR))
        o_current_instr <= o_next_instr;
    end
  end

  // target and memory-op codes for the central data bus
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      target_code_reg_q    <= 2'h0;
      memory_op_code_reg_q <= 3'h0;
    end else if (sp && i_mcu_opt == MO_CODES_LOAD) begin
      target_code_reg_q    <= {wbit(i_cor, COR_TGT_HI),
                               wbit(i_cor, COR_TGT_LO)};
      memory_op_code_reg_q <= {wbit(i_cor, COR_MOP_HI),
                               wbit(i_cor, COR_MOP_MID),
                               wbit(i_cor, COR_MOP_LO)};
    end
  end

  // codes sit at the same bit positions they were taken from
  always_comb begin
    o_cdb_data = 16'h0000;
    o_cdb_data[15-COR_TGT_HI]  = target_code_reg_q[1];
    o_cdb_data[15-COR_TGT_LO]  = target_code_reg_q[0];
    o_cdb_data[15-COR_MOP_HI]  = memory_op_code_reg_q[2];
    o_cdb_data[15-COR_MOP_MID] = memory_op_code_reg_q[1];
    o_cdb_data[15-COR_MOP_LO]  = memory_op_code_reg_q[0];
  end
  assign o_cdb_oe = sp && (i_mcu_opt == MO_CODES_OUT);

  // memory requests: one-cycle pulse after the microcycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_req <= 1'b0;
      o_mem_op  <= MEM_NONE;
    end else begin
      o_mem_req <= 1'b0;
      o_mem_op  <= MEM_NONE;
      if (sp) begin
        o_mem_req <= 1'b1;
        if (i_mcu_opt[4:3] == MO_BOTH_PREFIX) o_mem_op <= MEM_READ_BOTH;
        else begin
          unique case (i_mcu_opt)
            MO_READ_OPND:   o_mem_op <= MEM_READ_OPND;
            MO_READ_NEXT:   o_mem_op <= MEM_READ_NEXT;
            MO_READ_NOREST: o_mem_op <= MEM_READ_NORS;
            MO_ZERO_WRITE:  o_mem_op <= MEM_ZERO_WR;
            default:        o_mem_req <= 1'b0;
          endcase
        end
      end
    end
  end

  // r-bus register
  assign tos_sel = o_name + {wbit(i_scratch_pad_one, SCR_NAME_HI),
                             wbit(i_scratch_pad_one, SCR_NAME_LO)};
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rbus <= 16'h0000;
    end else if (sp && i_rbus_code == RB_ZERO) begin
      o_rbus <= 16'h0000;
    end else if (sp && i_rbus_code == RB_TOS_FETCH) begin
      unique case (tos_sel)
        2'h0: o_rbus <= i_tos_0;
        2'h1: o_rbus <= i_tos_1;
        2'h2: o_rbus <= i_tos_2;
        2'h3: o_rbus <= i_tos_3;
      endcase
    end
  end

  // apb: zero wait states, read data captured in the setup phase
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !(i_paddr == A_STATUS
    || i_paddr == A_PEND || i_paddr == A_STAT2 || i_paddr == A_COUNT
    || i_paddr == A_INSTR || i_paddr == A_RBUS);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        A_STATUS: o_prdata <= {16'h0000, o_int_enable, o_freeze,
          o_panel_lamp, o_name, o_depth, o_indirect, o_overflow,
          o_flag3, o_flag2, o_flag1, o_carry, o_cond_code};
        A_PEND:   o_prdata <= {16'h0000, o_int_pending};
        A_STAT2:  o_prdata <= {16'h0000, o_int_status2};
        A_COUNT:  o_prdata <= 32'(o_counter);
        A_INSTR:  o_prdata <= {o_current_instr, o_next_instr};
        A_RBUS:   o_prdata <= {16'h0000, o_rbus};
        default:  o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_cond_fixed: assert property (sp && i_special == SP_COND_LESS
    |=> o_cond_code == CC_LESS) else $error("less code not set");
  chk_cond_zero_test: assert property (sp && i_special == SP_COND_ZERO
    |=> o_cond_code == (($past(i_tbus) == 16'h0000) ? CC_EQUAL
        : CC_GREATER)) else $error("zero test wrong");
  chk_pend_clear: assert property (clr_op && wbit(i_ubus, 4)
    && !pend_set[4] |=> !o_int_pending[4])
    else $error("timer pending not cleared");
  chk_int_off: assert property (clr_op && wbit(i_ubus, UB_INT_OFF)
    && !int_rearm |=> !o_int_enable ##1 (!o_int_enable || $past(int_rearm)))
    else $error("interrupts not held off");
  chk_instr_copy: assert property (clr_op && wbit(i_ubus, 0)
    |=> o_current_instr == $past(o_next_instr) && o_indirect)
    else $error("instruction copy wrong");
  chk_carry_ops: assert property (sp && (i_special == SP_CARRY_SET
    || i_special == SP_CARRY_RESET) |=> o_carry == $past(i_special
    == SP_CARRY_SET)) else $error("carry ops wrong");
  chk_pop_stack: assert property (pop |=> o_depth ==
    3'($past(o_depth) - 3'h1) && o_name == 2'($past(o_name) + 2'h1))
    else $error("pop wrong");
  chk_depth_clear: assert property (sp && i_special == SP_DEPTH_ZERO
    |=> o_depth == 3'h0) else $error("depth not cleared");
  chk_mem_norest: assert property (sp && i_mcu_opt == MO_READ_NOREST
    |=> o_mem_req && o_mem_op == MEM_READ_NORS ##1 (!o_mem_req || $past(sp)))
    else $error("no-restore request wrong");
  chk_rbus_zero: assert property (sp && i_rbus_code == RB_ZERO
    |=> o_rbus == 16'h0000) else $error("r-bus not zeroed");
  chk_idle_hold: assert property (!sp |=> $stable(o_depth)
    && $stable(o_flag1) && $stable(o_cond_code) && $stable(o_carry))
    else $error("state changed without microcycle");

  cov_pop_cond: cover property (sp && i_special == SP_POP_COND);
  cov_int_off:  cover property (clr_op && wbit(i_ubus, UB_INT_OFF));
  cov_tos_read: cover property (sp && i_rbus_code == RB_TOS_FETCH);
  cov_zero_wr:  cover property (sp && i_mcu_opt == MO_ZERO_WRITE);

endmodule : mcd_field_decoder

// >>> pkg/mcd_pkg.sv
package mcd_pkg;
  // special field codes
  localparam logic [4:0] SP_IDLE          = 5'h1f;
  localparam logic [4:0] SP_COND_SIGN     = 5'h1e;
  localparam logic [4:0] SP_COND_EQUAL    = 5'h1d;
  localparam logic [4:0] SP_COND_GREATER  = 5'h1c;
  localparam logic [4:0] SP_COND_LESS     = 5'h1b;
  localparam logic [4:0] SP_COND_ZERO     = 5'h1a;
  localparam logic [4:0] SP_OVF_RESET     = 5'h19;
  localparam logic [4:0] SP_OVF_SET       = 5'h18;
  localparam logic [4:0] SP_POP           = 5'h17;
  localparam logic [4:0] SP_POP_COND      = 5'h16;
  localparam logic [4:0] SP_CARRY_RESET   = 5'h15;
  localparam logic [4:0] SP_CARRY_SET     = 5'h14;
  localparam logic [4:0] SP_FLAG1_SET     = 5'h13;
  localparam logic [4:0] SP_FLAG1_RESET   = 5'h12;
  localparam logic [4:0] SP_FLAG2_RESET   = 5'h11;
  localparam logic [4:0] SP_FLAG2_SET     = 5'h10;
  localparam logic [4:0] SP_LOW_TO_FLAG   = 5'h0f;
  localparam logic [4:0] SP_IND_RESET     = 5'h0e;
  localparam logic [4:0] SP_FLAG_TO_TOP   = 5'h0d;
  localparam logic [4:0] SP_TOP_TO_FLAG   = 5'h0c;
  localparam logic [4:0] SP_COUNT_INC     = 5'h0b;
  localparam logic [4:0] SP_NAME_INC      = 5'h0a;
  localparam logic [4:0] SP_DEPTH_DEC     = 5'h09;
  localparam logic [4:0] SP_DEPTH_INC     = 5'h08;
  localparam logic [4:0] SP_FLAG3_RESET   = 5'h07;
  localparam logic [4:0] SP_CARRY_TO_FLAG = 5'h06;
  localparam logic [4:0] SP_DISP_SET      = 5'h05;
  localparam logic [4:0] SP_ISTK_SET      = 5'h04;
  localparam logic [4:0] SP_HALT          = 5'h03;
  localparam logic [4:0] SP_DEPTH_ZERO    = 5'h02;
  localparam logic [4:0] SP_INT_CLEAR     = 5'h01;
  // condition code values
  localparam logic [1:0] CC_GREATER = 2'h0;
  localparam logic [1:0] CC_LESS    = 2'h1;
  localparam logic [1:0] CC_EQUAL   = 2'h2;
  // memory option codes
  localparam logic [4:0] MO_CODES_OUT   = 5'h18;
  localparam logic [4:0] MO_CODES_LOAD  = 5'h19;
  localparam logic [4:0] MO_NEXT_LOAD   = 5'h1a;
  localparam logic [4:0] MO_READ_NEXT   = 5'h1b;
  localparam logic [4:0] MO_READ_NOREST = 5'h1d;
  localparam logic [4:0] MO_ZERO_WRITE  = 5'h1e;
  localparam logic [4:0] MO_READ_OPND   = 5'h1f;
  localparam logic [1:0] MO_BOTH_PREFIX = 2'h2;
  // r-bus field codes
  localparam logic [3:0] RB_ZERO      = 4'hf;
  localparam logic [3:0] RB_TOS_FETCH = 4'h3;
  // word bit positions, numbered from the most significant bit, except X2_RUN, X2_ISTK and X2_DISP, counted from the lsb
  localparam int UB_COPY_INSTR = 0;
  localparam int UB_INT_OFF    = 10;
  localparam int UB_ISTK_CLR   = 11;
  localparam int UB_DISP_CLR   = 12;
  localparam int UB_LAMP       = 13;
  localparam int UB_FREEZE     = 14;
  localparam int UB_PANEL_ALT  = 15;
  localparam int PEND_FIRST    = 1;
  localparam int PEND_PANEL    = 9;
  localparam int X2_RUN        = 0;
  localparam int X2_ISTK       = 11;
  localparam int X2_DISP       = 12;
  localparam int COR_TGT_HI    = 10;
  localparam int COR_TGT_LO    = 11;
  localparam int COR_MOP_HI    = 13;
  localparam int COR_MOP_MID   = 14;
  localparam int COR_MOP_LO    = 15;
  localparam int SCR_NAME_HI   = 14;
  localparam int SCR_NAME_LO   = 15;
  // apb byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_PEND   = 8'h04;
  localparam logic [7:0] A_STAT2  = 8'h08;
  localparam logic [7:0] A_COUNT  = 8'h0c;
  localparam logic [7:0] A_INSTR  = 8'h10;
  localparam logic [7:0] A_RBUS   = 8'h14;
  // reset values
  localparam logic [15:0] STAT2_RST  = 16'h0001;
  localparam logic        INT_EN_RST = 1'b1;
  localparam logic        IND_RST    = 1'b1;

  typedef enum logic [2:0] {
    MEM_NONE      = 3'h0,
    MEM_READ_OPND = 3'h1,
    MEM_READ_BOTH = 3'h2,
    MEM_READ_NEXT = 3'h3,
    MEM_READ_NORS = 3'h4,
    MEM_ZERO_WR   = 3'h5
  } mcd_mem_op_t;
endpackage : mcd_pkg

// >>> testbench/mcd_mem_model.sv
`timescale 1ns/10ps
module mcd_mem_model import mcd_pkg::*; #(
  parameter logic [15:0] REPLY = 16'h5a3c
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_mem_req,
  input  wire mcd_mem_op_t i_mem_op,
  output logic      [15:0] o_cdb,
  output int               o_ops
);
  // idle bus shows the inverse so a stale reply cannot pass for data
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cdb <= ~REPLY;
      o_ops <= 0;
    end else if (i_mem_req && i_mem_op != MEM_NONE) begin
      o_cdb <= REPLY;
      o_ops <= o_ops + 1;
    end else begin
      o_cdb <= ~REPLY;
    end
  end
endmodule : mcd_mem_model

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top import mcd_pkg::*;;
  localparam logic [15:0] RPLY = 16'h5a3c;
  localparam logic [15:0] IDLE_BUS = ~RPLY;
  logic cdb_oe, u0, u0_oe;
  logic [2:0] seen;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic exec = 1'b0, rearm = 1'b0, rsw = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [4:0] sp = 5'h1f, op = 5'h00;
  logic [3:0] rb = 4'h5;
  logic [15:0] tb = 16'h0, ub = 16'h0, cor = 16'h0035, spo = 16'h0001;
  logic [15:0] cdb, pend, st2, cur, nxt, cdbd, rbus, cnt;
  logic pready, slverr, e, carry, f1, f2, f3, ovf, ind, ien, lamp, frz, req;
  logic [1:0] cc, name;
  logic [2:0] depth;
  mcd_mem_op_t mop;
  int err_total = 0, compares = 0, cyc = 0, ops;
  logic [4:0] ol [5] = '{MO_READ_OPND, 5'h12, MO_READ_NEXT, MO_READ_NOREST,
                         MO_ZERO_WRITE};
  mcd_field_decoder dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr), .i_exec(exec),
    .i_special(sp), .i_mcu_opt(op), .i_rbus_code(rb), .i_tbus(tb),
    .i_ubus(ub), .i_cor(cor), .i_scratch_pad_one(spo), .i_cdb(cdb),
    .i_tos_0(16'h0a00), .i_tos_1(16'h0a01), .i_tos_2(16'h0a02),
    .i_tos_3(16'h0a03), .i_fetch_rearm(rearm), .i_reset_switch(rsw),
    .i_power_fail(1'b0), .o_cond_code(cc), .o_carry(carry), .o_flag1(f1),
    .o_flag2(f2), .o_flag3(f3), .o_overflow(ovf), .o_indirect(ind),
    .o_depth(depth), .o_name(name), .o_counter(cnt), .o_int_pending(pend),
    .o_int_status2(st2), .o_int_enable(ien), .o_panel_lamp(lamp),
    .o_freeze(frz), .o_current_instr(cur), .o_next_instr(nxt), .o_ubus0(u0),
    .o_ubus0_oe(u0_oe), .o_cdb_data(cdbd), .o_cdb_oe(cdb_oe), .o_mem_req(req),
    .o_mem_op(mop), .o_rbus(rbus));
  mcd_mem_model #(.REPLY(RPLY)) mcu (.i_ref_clk(clk), .i_rst(rst),
    .i_mem_req(req), .i_mem_op(mop), .o_cdb(cdb), .o_ops(ops));
  always #5 clk = ~clk;
  // bus enables stand only while exec is high, so keep the last edge's view
  always @(posedge clk) seen <= {cdb_oe, u0_oe, u0};
  task summarize;
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task ex(input logic [4:0] s, input logic [4:0] o = 5'h00,
          input logic [15:0] u = 16'h0, input logic [15:0] t = 16'h1,
          input logic [3:0] r = 4'h5);
    @(posedge clk);
    exec <= 1'b1; sp <= s; op <= o; ub <= u; tb <= t; rb <= r;
    @(posedge clk);
    exec <= 1'b0; sp <= 5'h1f; op <= 5'h00; rb <= 4'h5;
    #1;
  endtask : ex
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the cycle ceiling ends a hang here
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task fx(input logic [4:0] s, input logic [15:0] u, input logic [4:0] x);
    ex(s, , u);
    chk({carry, f1, f2, f3, ovf}, x);
  endtask : fx
  task t_cond;
    ex(SP_COND_LESS); chk(cc, CC_LESS);
    ex(SP_COND_GREATER); chk(cc, CC_GREATER);
    ex(SP_COND_EQUAL); chk(cc, CC_EQUAL);
    ex(SP_COND_ZERO, , , 16'h0001); chk(cc, CC_GREATER);
    ex(SP_COND_ZERO, , , 16'h0000); chk(cc, CC_EQUAL);
    ex(SP_IDLE, , , 16'h8000); chk(cc, CC_EQUAL);
  endtask : t_cond
  task t_flags;
    fx(SP_CARRY_SET, 16'h0, 5'b10000);
    fx(SP_CARRY_TO_FLAG, 16'h0, 5'b11000);
    fx(SP_CARRY_RESET, 16'h0, 5'b01000);
    fx(SP_FLAG1_RESET, 16'h0, 5'b00000);
    fx(SP_FLAG2_SET, 16'h0, 5'b00100);
    fx(SP_FLAG1_SET, 16'h0, 5'b01100);
    fx(SP_FLAG2_RESET, 16'h0, 5'b01000);
    fx(SP_TOP_TO_FLAG, 16'h7fff, 5'b00000);
    fx(SP_LOW_TO_FLAG, 16'h0001, 5'b00100);
    fx(SP_TOP_TO_FLAG, 16'h8000, 5'b01100);
    fx(SP_OVF_SET, 16'h0, 5'b01101);
    fx(SP_FLAG3_RESET, 16'h0, 5'b01101);
    fx(SP_OVF_RESET, 16'h0, 5'b01100);
    apb(1'b0, A_STATUS, 32'h0); chk(q, 32'h809a);
  endtask : t_flags
  task t_stack;
    repeat (3) ex(SP_DEPTH_INC);
    chk(depth, 3'd3);
    ex(SP_DEPTH_DEC); chk(depth, 3'd2);
    ex(SP_POP); chk({depth, name}, {3'd1, 2'd1});
    ex(SP_NAME_INC); chk(name, 2'd2);
    ex(SP_POP_COND, , , 16'h8000); chk({depth, name, cc}, 7'h0d);
    ex(SP_COUNT_INC); chk(cnt, 16'h0001);
    ex(SP_DEPTH_INC);
    ex(SP_DEPTH_ZERO); chk(depth, 3'd0);
    // name 3 plus scratch pad 1 wraps to the first stack register
    ex(SP_IDLE, , , , RB_TOS_FETCH); chk(rbus, 16'h0a00);
    ex(SP_IDLE, , , , RB_ZERO); chk(rbus, 16'h0000);
  endtask : t_stack
  task t_status;
    apb(1'b1, A_PEND, 32'h3fe);
    apb(1'b0, A_PEND, 32'h0); chk(q, 32'h3fe);
    ex(SP_INT_CLEAR, , 16'h7f80); chk(pend, 16'h0200);
    ex(SP_INT_CLEAR, , 16'h0001); chk(pend, 16'h0000);
    apb(1'b0, 8'h40, 32'h0); chk(q, 32'h0); chk(e, 1'b1);
    ex(SP_ISTK_SET);
    ex(SP_DISP_SET); chk(st2, 16'h1801);
    ex(SP_HALT); chk(st2, 16'h1800);
    ex(SP_INT_CLEAR, , 16'h0018); chk(st2, 16'h0000);
    ex(SP_INT_CLEAR, , 16'h0026); chk({ien, lamp, frz}, 3'b011);
    @(posedge clk) rsw <= 1'b1;
    repeat (4) @(posedge clk);
    rsw <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({ien, frz}, 2'b10);
  endtask : t_status
  task t_mem;
    for (int i = 0; i < 5; i++) begin
      ex(SP_IDLE, ol[i]); chk({req, mop}, {1'b1, 3'(i + 1)});
      @(posedge clk);
      #1 chk(req, 1'b0);
    end
    chk(ops, 5);
    ex(SP_IDLE, MO_CODES_LOAD); chk(cdbd, 16'h0035);
    ex(SP_IDLE, MO_CODES_OUT); chk(req, 1'b0);
    chk(seen, 3'b101);
    ex(SP_FLAG_TO_TOP); chk(seen, 3'b011);
  endtask : t_mem
  task t_instr;
    ex(SP_IND_RESET); chk(ind, 1'b0);
    @(posedge clk);
    rearm <= 1'b1;
    @(posedge clk);
    rearm <= 1'b0;
    #1 chk(ind, 1'b1);
    ex(SP_IND_RESET);
    ex(SP_IDLE, MO_NEXT_LOAD); chk(nxt, IDLE_BUS);
    ex(SP_INT_CLEAR, , 16'h8000); chk({cur, ind}, {IDLE_BUS, 1'b1});
  endtask : t_instr
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_cond;
    t_flags;
    t_stack;
    t_status;
    t_mem;
    t_instr;
    summarize;
  end
endmodule : tb_top
